//--- shared/rtc_cfg.svh
// constants for the clock/calendar timekeeping core
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ************************************************************
// clock rates and timing
// ************************************************************
`define REF_HZ 26'd40000000
`define XTAL_HZ 26'd32768
`define UIP_LEAD_US 244
`define US_PER_S 1000000
`define DIV_W 15
`define DIV_FULL 15'h7fff
`define DIV_HALF 15'h4000

// ************************************************************
// register offsets
// ************************************************************
`define ADDR_W 4
`define CAL_BYTES 10
`define OFS_SEC 4'h0
`define OFS_ASEC 4'h1
`define OFS_MIN 4'h2
`define OFS_AMIN 4'h3
`define OFS_HOUR 4'h4
`define OFS_AHOUR 4'h5
`define OFS_DOW 4'h6
`define OFS_DATE 4'h7
`define OFS_MON 4'h8
`define OFS_YEAR 4'h9
`define OFS_CTRL_A 4'ha
`define OFS_CTRL_B 4'hb
`define OFS_STAT 4'hc

// ************************************************************
// field positions
// ************************************************************
`define A_UIP 7
`define B_SET 7
`define B_PIE 6
`define B_AIE 5
`define B_UIE 4
`define B_SQUARE_WAVE_ENABLE 3
`define B_DM 2
`define B_H24 1
`define B_DSE 0
`define HR_PM 7
`define SEC_WMASK 8'h7f
`define FULL_WMASK 8'hff
`define WILD_CODE 2'b11

// ************************************************************
// counting limits, binary
// ************************************************************
`define BCD_RADIX 7'h0a
`define SEC_MAX 7'h3b
`define HR24_MAX 7'h17
`define HR12_MAX 7'h0c
`define HR12_PRE 7'h0b
`define DOW_MAX 7'h07
`define MON_MAX 7'h0c
`define YEAR_MAX 7'h63
`define ONE 7'h01
`define ZERO 7'h00
`define SUNDAY 7'h01
`define APRIL 7'h04
`define OCTOBER 7'h0a
`define FEB 7'h02
`define APR 7'h04
`define JUN 7'h06
`define SEP 7'h09
`define NOV 7'h0b
`define DAYS_31 7'h1f
`define DAYS_30 7'h1e
`define DAYS_29 7'h1d
`define DAYS_28 7'h1c
`define DST_HOUR 7'h01
`define DST_JUMP 7'h03
`define WEEK_LAST 7'h07
`define OCT_LAST_SUN 7'h19
`define RS_LOW_CODES 4'h3
`define RS_LOW_TAP 4'h5
`define RS_HIGH_TAP 4'h2

// ************************************************************
// power-on values
// ************************************************************
`define CAL_RST_ZERO 8'h00
`define CAL_RST_ONE 8'h01
`define OSC_RST 3'h0
`define RS_RST 4'h0

`endif

//--- shared/rtc_pkg.sv
// types for the clock/calendar timekeeping core
package rtc_pkg;
    typedef logic [7:0] cal_byte_t;
    typedef logic [6:0] bin_t;
    // oscillator control patterns, one-hot state of the chain
    typedef enum logic [2:0] {
        OSC_OFF = 3'b001,
        OSC_RUN = 3'b010,
        OSC_HOLD = 3'b100
    } osc_mode_t;
endpackage

//--- src/rtc_core.sv
// timekeeping, alarm and control core of the clock/calendar
`include "rtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rtc_core
    import rtc_pkg::*;
(
    // clock and resets
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic por,
    // register port
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // pins
    output logic irq_oe,
    output logic sqw
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic bin_t to_bin(input cal_byte_t v, input logic bin);
        return bin ? v[6:0] : 7'(v[7:4] * 4'ha + v[3:0]);
    endfunction

    function automatic cal_byte_t to_fmt(input bin_t b, input logic bin);
        return bin ? {1'b0, b} : {4'(b / `BCD_RADIX), 4'(b % `BCD_RADIX)};
    endfunction

    // ************************************************************
    // storage
    // ************************************************************
    cal_byte_t cal_r [0:`CAL_BYTES-1];
    cal_byte_t cal_nxt [0:`CAL_BYTES-1];
    logic [2:0] osc_r;
    logic [3:0] rs_r;
    logic set_r, pie_r, aie_r, uie_r, square_wave_enable_r, dm_r, h24_r, dse_r;
    logic pf_r, af_r, uf_r;
    logic [25:0] acc_r;
    logic [`DIV_W-1:0] div_r;
    logic tap_q_r;
    logic upd_d_r;
    logic fall_done_r;
    logic [7:0] rd_data_r;
    logic irq_oe_r;
    logic sqw_r;

    // ************************************************************
    // access decode
    // ************************************************************
    wire logic acc_ok = ~srst & ~por;
    wire logic wr_en = wr_stb & acc_ok;
    wire logic rd_en = rd_stb & acc_ok;
    wire logic wr_a = wr_en & (addr == `OFS_CTRL_A);
    wire logic wr_b = wr_en & (addr == `OFS_CTRL_B);
    wire logic rd_c = rd_en & (addr == `OFS_STAT);

    // ************************************************************
    // 32.768 khz tick and divider chain
    // ************************************************************
    wire logic [25:0] acc_sum = acc_r + `XTAL_HZ;
    wire logic tick = acc_sum >= `REF_HZ;
    osc_mode_t osc_mode;
    always_comb begin
        case (osc_r)
            3'b010: osc_mode = OSC_RUN;
            3'b110, 3'b111: osc_mode = OSC_HOLD;
            default: osc_mode = OSC_OFF;
        endcase
    end
    wire logic run = (osc_mode == OSC_RUN);
    wire logic [`DIV_W-1:0] uip_ticks =
        `DIV_W'((`UIP_LEAD_US * 32768 + `US_PER_S - 1) / `US_PER_S);
    wire logic sec_evt = run & tick & (div_r == `DIV_FULL);
    wire logic upd = sec_evt & ~set_r;
    wire logic update_pending = run & ~set_r & (div_r > (`DIV_FULL - uip_ticks));

    always_ff @(posedge ref_clk) begin
        if (tick) begin
            acc_r <= acc_sum - `REF_HZ;
        end else begin
            acc_r <= acc_sum;
        end
    end

    // held chain restarts half way so the first second lasts 500 ms
    always_ff @(posedge ref_clk) begin
        if (!run) begin
            div_r <= `DIV_HALF;
        end else if (tick) begin
            div_r <= div_r + 1'b1;
        end
    end

    // ************************************************************
    // rate tap
    // ************************************************************
    wire logic [3:0] tap_idx = (rs_r < `RS_LOW_CODES) ? (rs_r + `RS_LOW_TAP)
                                                      : (rs_r - `RS_HIGH_TAP);
    wire logic tap_on = (rs_r != 4'h0);
    wire logic tap_bit = tap_on & div_r[tap_idx];
    wire logic per_evt = tap_bit & ~tap_q_r;

    // ************************************************************
    // next calendar values, all arithmetic in binary
    // ************************************************************
    wire logic bin = dm_r;
    wire bin_t s_b = to_bin({1'b0, cal_r[`OFS_SEC][6:0]}, bin);
    wire bin_t m_b = to_bin(cal_r[`OFS_MIN], bin);
    wire bin_t h_b = to_bin({1'b0, cal_r[`OFS_HOUR][6:0]}, bin);
    wire logic pm = ~h24_r & cal_r[`OFS_HOUR][`HR_PM];
    wire bin_t dw_b = to_bin(cal_r[`OFS_DOW], bin);
    wire bin_t dt_b = to_bin(cal_r[`OFS_DATE], bin);
    wire bin_t mo_b = to_bin(cal_r[`OFS_MON], bin);
    wire bin_t yr_b = to_bin(cal_r[`OFS_YEAR], bin);
    wire logic leap = (yr_b[1:0] == 2'b00);
    wire bin_t mlen = (mo_b == `FEB) ? (leap ? `DAYS_29 : `DAYS_28) :
                      ((mo_b == `APR) | (mo_b == `JUN) | (mo_b == `SEP) |
                       (mo_b == `NOV)) ? `DAYS_30 : `DAYS_31;
    wire logic c_min = (s_b == `SEC_MAX);
    wire logic c_hr = c_min & (m_b == `SEC_MAX);
    wire logic at_dst = c_hr & dse_r & (h_b == `DST_HOUR) & ~pm &
                        (dw_b == `SUNDAY);
    wire logic spring = at_dst & (mo_b == `APRIL) & (dt_b <= `WEEK_LAST);
    wire logic fall = at_dst & (mo_b == `OCTOBER) &
                      (dt_b >= `OCT_LAST_SUN) & ~fall_done_r;

    bin_t s_n, m_n, h_n, dw_n, dt_n, mo_n, yr_n;
    logic pm_n, c_day, c_mon, c_yr;
    always_comb begin
        s_n = c_min ? `ZERO : s_b + `ONE;
        m_n = c_min ? ((m_b == `SEC_MAX) ? `ZERO : m_b + `ONE) : m_b;
        h_n = h_b;
        pm_n = pm;
        c_day = 1'b0;
        if (c_hr) begin
            if (h24_r) begin
                c_day = (h_b == `HR24_MAX);
                h_n = c_day ? `ZERO : h_b + `ONE;
            end else if (h_b == `HR12_PRE) begin
                h_n = `HR12_MAX;
                pm_n = ~pm;
                c_day = pm;
            end else if (h_b == `HR12_MAX) begin
                h_n = `ONE;
            end else begin
                h_n = h_b + `ONE;
            end
        end
        if (spring) begin
            h_n = `DST_JUMP;
        end
        if (fall) begin
            h_n = `DST_HOUR;
        end
        c_mon = c_day & (dt_b >= mlen);
        c_yr = c_mon & (mo_b == `MON_MAX);
        dw_n = c_day ? ((dw_b >= `DOW_MAX) ? `ONE : dw_b + `ONE) : dw_b;
        dt_n = c_day ? (c_mon ? `ONE : dt_b + `ONE) : dt_b;
        mo_n = c_mon ? (c_yr ? `ONE : mo_b + `ONE) : mo_b;
        yr_n = c_yr ? ((yr_b == `YEAR_MAX) ? `ZERO : yr_b + `ONE) : yr_b;
    end

    wire cal_byte_t hour_fmt = to_fmt(h_n, bin);
    always_comb begin
        for (int k = 0; k < `CAL_BYTES; k++) begin
            cal_nxt[k] = cal_r[k];
        end
        cal_nxt[`OFS_SEC] = to_fmt(s_n, bin);
        cal_nxt[`OFS_MIN] = to_fmt(m_n, bin);
        cal_nxt[`OFS_HOUR] = h24_r ? hour_fmt : {pm_n, hour_fmt[6:0]};
        cal_nxt[`OFS_DOW] = to_fmt(dw_n, bin);
        cal_nxt[`OFS_DATE] = to_fmt(dt_n, bin);
        cal_nxt[`OFS_MON] = to_fmt(mo_n, bin);
        cal_nxt[`OFS_YEAR] = to_fmt(yr_n, bin);
    end

    // ************************************************************
    // calendar and alarm bytes
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `CAL_BYTES; gi++) begin : g_cal
            localparam cal_byte_t RST = ((gi == `OFS_DOW) || (gi == `OFS_DATE) ||
                                         (gi == `OFS_MON)) ? `CAL_RST_ONE : `CAL_RST_ZERO;
            localparam cal_byte_t WMASK = (gi == `OFS_SEC) ? `SEC_WMASK : `FULL_WMASK;
            wire logic hit = wr_en & (addr == `ADDR_W'(gi));
            always_ff @(posedge ref_clk) begin
                if (por) begin
                    cal_r[gi] <= RST;
                end else if (hit) begin
                    cal_r[gi] <= wr_data & WMASK;
                end else if (upd) begin
                    cal_r[gi] <= cal_nxt[gi];
                end
            end
        end
    endgenerate

    // fall back happens once per day
    always_ff @(posedge ref_clk) begin
        if (por) begin
            fall_done_r <= 1'b0;
        end else if (upd & fall) begin
            fall_done_r <= 1'b1;
        end else if (upd & c_day) begin
            fall_done_r <= 1'b0;
        end
    end

    // ************************************************************
    // alarm compare, one cycle after the advance
    // ************************************************************
    wire logic [2:0] amatch;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_alm
            wire cal_byte_t t = cal_r[2 * gi];
            wire cal_byte_t a = cal_r[2 * gi + 1];
            assign amatch[gi] = (a[7:6] == `WILD_CODE) | (a == t);
        end
    endgenerate
    wire logic alarm_evt = upd_d_r & (&amatch);

    always_ff @(posedge ref_clk) begin
        if (por | srst) begin
            upd_d_r <= 1'b0;
            tap_q_r <= 1'b0;
        end else begin
            upd_d_r <= upd;
            tap_q_r <= tap_bit;
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (por) begin
            osc_r <= `OSC_RST;
            rs_r <= `RS_RST;
            set_r <= 1'b0;
            dm_r <= 1'b0;
            h24_r <= 1'b0;
            dse_r <= 1'b0;
        end else if (wr_a) begin
            osc_r <= wr_data[6:4];
            rs_r <= wr_data[3:0];
        end else if (wr_b) begin
            set_r <= wr_data[`B_SET];
            dm_r <= wr_data[`B_DM];
            h24_r <= wr_data[`B_H24];
            dse_r <= wr_data[`B_DSE];
        end
    end

    // enables cleared by reset; update enable also by inhibit
    always_ff @(posedge ref_clk) begin
        if (por | srst) begin
            pie_r <= 1'b0;
            aie_r <= 1'b0;
            uie_r <= 1'b0;
            square_wave_enable_r <= 1'b0;
        end else if (wr_b) begin
            pie_r <= wr_data[`B_PIE];
            aie_r <= wr_data[`B_AIE];
            uie_r <= wr_data[`B_UIE] & ~wr_data[`B_SET];
            square_wave_enable_r <= wr_data[`B_SQUARE_WAVE_ENABLE];
        end
    end

    // ************************************************************
    // flags: a new event wins over the read clear
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (por | srst) begin
            pf_r <= 1'b0;
            af_r <= 1'b0;
            uf_r <= 1'b0;
        end else begin
            pf_r <= (pf_r & ~rd_c) | per_evt;
            af_r <= (af_r & ~rd_c) | alarm_evt;
            uf_r <= (uf_r & ~rd_c) | upd_d_r;
        end
    end

    wire logic pf_n = (pf_r & ~rd_c) | per_evt;
    wire logic af_n = (af_r & ~rd_c) | alarm_evt;
    wire logic uf_n = (uf_r & ~rd_c) | upd_d_r;
    wire logic irq_now = (pf_r & pie_r) | (af_r & aie_r) | (uf_r & uie_r);
    wire logic irq_nxt = (pf_n & pie_r) | (af_n & aie_r) | (uf_n & uie_r);

    // ************************************************************
    // read mux
    // ************************************************************
    wire logic [7:0] reg_a = {update_pending, osc_r, rs_r};
    wire logic [7:0] reg_b = {set_r, pie_r, aie_r, uie_r, square_wave_enable_r, dm_r, h24_r, dse_r};
    wire logic [7:0] reg_c = {irq_now, pf_r, af_r, uf_r, 4'h0};
    wire logic [7:0] rd_mux = (addr < `ADDR_W'(`CAL_BYTES)) ? cal_r[addr] :
                              (addr == `OFS_CTRL_A) ? reg_a :
                              (addr == `OFS_CTRL_B) ? reg_b :
                              (addr == `OFS_STAT) ? reg_c : 8'h00;

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (por | srst) begin
            rd_data_r <= 8'h00;
            irq_oe_r <= 1'b0;
            sqw_r <= 1'b0;
        end else begin
            rd_data_r <= rd_en ? rd_mux : 8'h00;
            irq_oe_r <= irq_nxt;
            sqw_r <= square_wave_enable_r & tap_bit;
        end
    end

    assign rd_data = rd_data_r;
    assign irq_oe = irq_oe_r;
    assign sqw = sqw_r;

endmodule // rtc_core

`default_nettype wire

//--- tb/host_model.sv
// host processor driving the register port
`include "rtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output var logic [`ADDR_W-1:0] addr,
    output var logic [7:0] wr_data,
    output var logic wr_stb,
    output var logic rd_stb,
    input wire logic [7:0] rd_data
);
    initial begin
        addr = 4'h0;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end
    // released lines show inverted data, not the last value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        addr <= ~a;
        wr_data <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        addr <= ~a;
        // answer stands only until the next edge, take it mid-cycle
        @(negedge ref_clk);
        d = rd_data;
    endtask
    // inhibit first, then all ten bytes in one format
    task automatic load_time(input logic [7:0] mode, input logic [79:0] bytes);
        wr(`OFS_CTRL_B, mode | 8'h80);
        for (int i = 0; i < 10; i++) begin
            wr(i[3:0], bytes[8*i+:8]);
        end
    endtask
endmodule // host_model
`default_nettype wire

//--- tb/rtc_core_assertions.sv
// port checks for the timekeeping core
`include "rtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rtc_core_assertions (
    // clock and resets
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic por,
    // register port
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data,
    // pins
    input wire logic irq_oe,
    input wire logic sqw
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst || por);
    logic en_seen_r;
    wire wr_b = wr_stb && addr == `OFS_CTRL_B;
    wire rd_st = rd_stb && addr == `OFS_STAT;
    wire wr_al = wr_stb && (addr == `OFS_ASEC || addr == `OFS_AMIN || addr == `OFS_AHOUR);
    // any interrupt enable written since reset
    always_ff @(posedge ref_clk) begin
        if (srst || por) begin
            en_seen_r <= 1'b0;
        end else if (wr_b && |wr_data[6:4]) begin
            en_seen_r <= 1'b1;
        end
    end
    a_rd_idle_zero: assert property (!rd_stb |=> rd_data == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_stat_low_zero: assert property (rd_st |=> rd_data[3:0] == 4'h0)
        else $error("status low bits not zero");
    a_summary_cause: assert property (rd_st |=> !rd_data[7] || rd_data[6:4] != 3'h0)
        else $error("summary flag without a source flag");
    a_unmapped_zero: assert property (rd_stb && addr > `OFS_STAT |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_sec_top_zero: assert property (rd_stb && addr == `OFS_SEC |=> !rd_data[7])
        else $error("seconds top bit set");
    a_sqw_held_low: assert property (wr_b && !wr_data[3] ##1 !wr_b |=> !sqw)
        else $error("square wave high while disabled");
    a_reset_quiet: assert property (disable iff (por) srst |=> !irq_oe && !sqw && rd_data == 8'h00)
        else $error("outputs active after reset");
    a_irq_needs_enable: assert property (!en_seen_r |-> !irq_oe)
        else $error("interrupt without any enable");
    a_ctrl_b_back: assert property (wr_b ##1 !wr_stb ##1 (rd_stb && addr == `OFS_CTRL_B) |=> rd_data == ($past(wr_data, 3) & ($past(wr_data[7], 3) ? 8'hef : 8'hff)))
        else $error("control b readback wrong");
    a_ctrl_a_back: assert property ((wr_stb && addr == `OFS_CTRL_A) ##1 !wr_stb ##1 (rd_stb && addr == `OFS_CTRL_A) |=> rd_data[6:0] == $past(wr_data[6:0], 3))
        else $error("control a readback wrong");
    a_alarm_back: assert property (wr_al ##1 !wr_stb ##1 (rd_stb && addr == $past(addr, 2)) |=> rd_data == $past(wr_data, 3))
        else $error("alarm byte readback wrong");
endmodule // rtc_core_assertions
bind rtc_core rtc_core_assertions i_rtc_core_assertions (.ref_clk(ref_clk), .srst(srst),
    .por(por), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .irq_oe(irq_oe), .sqw(sqw));
`default_nettype wire

//--- tb/rtc_core_tb_top.sv
// self-checking bench for the timekeeping core
`include "rtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rtc_core_tb_top;
    logic ref_clk, srst, por;
    wire logic [`ADDR_W-1:0] addr;
    wire logic [7:0] wr_data, rd_data;
    wire logic wr_stb, rd_stb, irq_oe, sqw;
    int n_fail, tests_run, n, r;
    logic [7:0] d;
    logic [79:0] tv = {8'h99, 8'h12, 8'h31, 8'h07, 8'h81, 8'h92, 8'hc5, 8'h45, 8'h30, 8'hd9};
    logic [7:0] rst_exp [0:12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
        8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    rtc_core i_rtc_core (.ref_clk(ref_clk), .srst(srst), .por(por), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .irq_oe(irq_oe), .sqw(sqw));
    host_model i_host_model (.ref_clk(ref_clk), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ************************************************************
    // checking helpers
    // ************************************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        i_host_model.rd(a, v);
        chk(v, exp);
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        while (irq_oe !== 1'b1 && k < 8000) begin
            @(negedge ref_clk);
            k++;
        end
        if (k == 8000) begin
            n_fail++;
            test_done();
        end
    endtask
    // counts square wave rises, and interrupt cycles in n
    task automatic watch(input int len, output int rises);
        logic prev;
        rises = 0;
        prev = sqw;
        repeat (len) begin
            @(negedge ref_clk);
            if (sqw === 1'b1 && prev !== 1'b1) rises++;
            if (irq_oe !== 1'b0) n++;
            prev = sqw;
        end
    endtask
    task automatic pulse_srst();
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        srst = 1'b1;
        por = 1'b1;
        n_fail = 0;
        tests_run = 0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        por <= 1'b0;
        for (int i = 0; i < 13; i++) rdc(i[3:0], rst_exp[i]);
        $display("test reset_values done");
        i_host_model.load_time(8'h00, tv);
        for (int i = 0; i < 10; i++) rdc(i[3:0], tv[8*i+:8] & (i == 0 ? 8'h7f : 8'hff));
        $display("test time_bytes done");
        i_host_model.wr(`OFS_CTRL_B, 8'hff);
        rdc(`OFS_CTRL_B, 8'hef);
        i_host_model.wr(`OFS_CTRL_B, 8'h7f);
        rdc(`OFS_CTRL_B, 8'h7f);
        i_host_model.wr(`OFS_CTRL_A, 8'hff);
        rdc(`OFS_CTRL_A, 8'h7f);
        pulse_srst();
        rdc(`OFS_CTRL_B, 8'h07);
        rdc(`OFS_CTRL_A, 8'h7f);
        rdc(`OFS_SEC, 8'h59);
        for (int i = 13; i < 16; i++) begin
            i_host_model.wr(i[3:0], 8'h5a);
            rdc(i[3:0], 8'h00);
        end
        i_host_model.wr(`OFS_AHOUR, 8'hc3);
        rdc(`OFS_AHOUR, 8'hc3);
        $display("test control_regs done");
        i_host_model.wr(`OFS_CTRL_A, 8'h23);
        i_host_model.wr(`OFS_CTRL_B, 8'h40);
        i_host_model.rd(`OFS_STAT, d);
        wait_irq();
        rdc(`OFS_STAT, 8'hc0);
        @(negedge ref_clk);
        chk({7'h00, irq_oe}, 8'h00);
        i_host_model.wr(`OFS_CTRL_B, 8'h00);
        n = 0;
        watch(6000, r);
        chk(n[7:0], 8'h00);
        rdc(`OFS_STAT, 8'h40);
        i_host_model.wr(`OFS_CTRL_A, 8'h20);
        i_host_model.rd(`OFS_STAT, d);
        repeat (6000) @(posedge ref_clk);
        rdc(`OFS_STAT, 8'h00);
        $display("test periodic done");
        i_host_model.wr(`OFS_CTRL_A, 8'h23);
        i_host_model.wr(`OFS_CTRL_B, 8'h08);
        watch(15000, n);
        chk({7'h00, n == 3 || n == 4}, 8'h01);
        i_host_model.wr(`OFS_CTRL_B, 8'h00);
        @(posedge ref_clk);
        watch(6000, n);
        chk(n[7:0], 8'h00);
        pulse_srst();
        rdc(`OFS_STAT, 8'h00);
        $display("test square_wave done");
        test_done();
    end
endmodule // rtc_core_tb_top
`default_nettype wire
